// [dv/scpg_sink.sv]
// Downstream sink model: pops sample words and keeps them with their flags.
// Assumes the generator's valid/ready stream on the one system clock.
`timescale 1ns/1ps
module scpg_sink #(
	parameter int N = 512
)(
	input wire logic i_clk_sys, // Clock
	input wire logic i_sys_rst, // Sync reset
	input wire logic i_stall, // Throttle ready
	input wire logic i_valid, // Word offered
	input wire logic [31:0] i_word, // sof, sol, ch2, ch1, ch0
	output logic o_ready, // Accept
	output int o_cnt // Words taken
);
	logic [31:0] mem [0:N-1]; // Captured words
	// ****************************************************************
	// Capture
	// ****************************************************************
	// Stalling toggles ready so the FIFO fills and the raster must wait
	always @(posedge i_clk_sys)
	begin
		if (i_sys_rst)
		begin
			o_ready <= 1'b0;
			o_cnt <= 0;
		end
		else
		begin
			o_ready <= i_stall ? ~o_ready : 1'b1;
			if (i_valid && o_ready && o_cnt < N)
			begin
				mem[o_cnt] <= i_word;
				o_cnt <= o_cnt + 1;
			end
		end
	end
endmodule

// [dv/scpg_sva.sv]
// Checker for the check-pattern generator ports.
// Assumes bind onto scpg_gen; one clock domain.
`timescale 1ns/1ps
module scpg_sva #(
	parameter int H_ACTIVE = 1920,
	parameter int V_ACTIVE = 1080
)(
	input wire logic i_clk_sys, // Clock
	input wire logic i_sys_rst, // Reset
	input wire logic [2:0] i_pattern, // Pattern
	input wire logic [1:0] i_format, // Format
	input wire logic i_ycbcr422, // 4:2:2
	input wire logic o_valid, // Valid
	input wire logic i_ready, // Ready
	input wire logic [9:0] o_ch0, // Luma
	input wire logic [9:0] o_ch1, // Blue
	input wire logic [9:0] o_ch2, // Red
	input wire logic o_sol, // Line start
	input wire logic o_sof // Frame start
);
	// ****************************************************************
	// Properties
	// ****************************************************************
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);
	a_rst_empty: assert property (@(posedge i_clk_sys) disable iff (1'b0) i_sys_rst |=> !o_valid)
		else $error("valid in reset");
	a_valid_soon: assert property ($fell(i_sys_rst) |-> ##[0:2] o_valid) else $error("no word after reset");
	a_word_holds: assert property (o_valid && !i_ready |=> o_valid && $stable(o_ch0) && $stable(o_ch1)
		&& $stable(o_ch2) && $stable(o_sol) && $stable(o_sof))
		else $error("word dropped");
	a_frame_line: assert property (o_valid && o_sof |-> o_sol) else $error("frame start off line");
	a_pll_words: assert property (o_valid && i_pattern == 3'h1 |-> o_ch0 inside {10'h200, 10'h110}
		&& o_ch1 == o_ch0 && o_ch2 == o_ch0) else $error("bad pll word");
	a_pll_restart: assert property (o_valid && i_pattern == 3'h1 && o_sol |-> o_ch0 == 10'h200)
		else $error("line parity");
	a_eq_words: assert property (o_valid && i_pattern == 3'h0 && !i_ycbcr422 |-> o_ch0 inside {10'h300, 10'h198})
		else $error("bad eq word");
	a_eq_chroma: assert property (o_valid && i_pattern == 3'h0 && i_ycbcr422 |-> o_ch1 == 10'h300
		&& o_ch2 == 10'h300 && o_ch0 inside {10'h198, 10'h190}) else $error("bad eq 422 word");
	a_cosite_edge: assert property (o_valid && i_pattern == 3'h5 && o_sol |-> o_ch0 == 10'h040)
		else $error("cosite background");
endmodule
bind scpg_gen scpg_sva #(.H_ACTIVE(H_ACTIVE), .V_ACTIVE(V_ACTIVE)) u_sva (.i_clk_sys(i_clk_sys),
	.i_sys_rst(i_sys_rst), .i_pattern(i_pattern), .i_format(i_format), .i_ycbcr422(i_ycbcr422),
	.o_valid(o_valid), .i_ready(i_ready), .o_ch0(o_ch0), .o_ch1(o_ch1), .o_ch2(o_ch2),
	.o_sol(o_sol), .o_sof(o_sof));

// [dv/tb_top.sv]
// Self-checking bench: captures two frames per pattern and judges them.
// Assumes a 64 x 4 raster so each run stays short.
`timescale 1ns/1ps
module tb_top;
	localparam int H = 64; // Samples per line
	localparam int V = 4; // Lines per frame
	localparam int N = 2 * H * V; // Two frames
	logic clk = 1'b0; // System clock
	logic rst = 1'b1; // Reset
	logic [2:0] pat = 3'h0; // Pattern
	logic [1:0] fmt = 2'h2; // Format
	logic y422 = 1'b0; // 4:2:2
	logic stall = 1'b0; // Throttle
	logic valid, ready, sol, sof; // Handshake and flags
	logic [9:0] c0, c1, c2; // Channels
	int cnt; // Captured words
	int miscompares = 0; // Mismatches
	int checks = 0; // Comparisons
	always #4 clk = ~clk;
	scpg_gen #(.H_ACTIVE(H), .V_ACTIVE(V)) DUT (.i_clk_sys(clk), .i_sys_rst(rst), .i_pattern(pat),
		.i_format(fmt), .i_ycbcr422(y422), .o_valid(valid), .i_ready(ready), .o_ch0(c0), .o_ch1(c1),
		.o_ch2(c2), .o_sol(sol), .o_sof(sof));
	scpg_sink #(.N(N)) SNK (.i_clk_sys(clk), .i_sys_rst(rst), .i_stall(stall), .i_valid(valid),
		.i_word({sof, sol, c2, c1, c0}), .o_ready(ready), .o_cnt(cnt));
	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [9:0] w(input int i, input int c);
		return SNK.mem[i][c*10+:10];
	endfunction
	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
		end
	endtask
	task automatic chkb(input logic got, input logic exp);
		checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
		end
	endtask
	// Reset with new settings, then wait for two frames under a bound
	task automatic run(input logic [2:0] p, input logic [1:0] f, input logic y, input logic s);
		int t;
		@(posedge clk);
		pat <= p;
		fmt <= f;
		y422 <= y;
		stall <= s;
		rst <= 1'b1;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t = 0;
		while (cnt < N && t < 4 * N)
		begin
			@(posedge clk);
			t++;
		end
		chkb(cnt >= N, 1'b1);
	endtask
	task automatic summarize();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	// Stalled sink: the FIFO backs up, no word may be lost
	task automatic t_eq();
		logic [9:0] e;
		run(3'h0, 2'h2, 1'b0, 1'b1);
		for (int i = 0; i < N; i++)
		begin
			e = (i % 2) ? 10'h198 : 10'h300;
			chk(w(i, 0), e);
			chk(w(i, 1), (i == H * V) ? 10'h190 : e);
			chk(w(i, 2), e);
			chkb(SNK.mem[i][30], (i % H) == 0);
			chkb(SNK.mem[i][31], (i % (H * V)) == 0);
		end
	endtask
	task automatic t_eq422();
		run(3'h0, 2'h2, 1'b1, 1'b0);
		for (int i = 0; i < N; i++)
		begin
			chk(w(i, 0), (i == H * V) ? 10'h190 : 10'h198);
			chk(w(i, 1), 10'h300);
			chk(w(i, 2), 10'h300);
		end
	endtask
	// Matrix: equalizer words above the middle line, PLL words below
	task automatic t_stress(input logic [2:0] p);
		logic top;
		run(p, 2'h1, 1'b0, 1'b1);
		for (int i = 0; i < H * V; i++)
		begin
			top = (p == 3'h2) && (i / H < V / 2);
			chk(w(i, 1), top ? ((i % 2) ? 10'h198 : 10'h300) : ((i % 2) ? 10'h110 : 10'h200));
		end
	endtask
	task automatic t_cosite();
		logic m;
		run(3'h5, 2'h2, 1'b0, 1'b0);
		for (int i = 0; i < H * V; i++)
		begin
			m = (i == (V / 2) * H + H / 2);
			chk(w(i, 0), m ? 10'h3ac : 10'h040);
			chk(w(i, 1), m ? 10'h300 : 10'h040);
			chk(w(i, 2), m ? 10'h280 : 10'h040);
		end
	endtask
	// Pulse width per format: half amplitude one half-width away from the centre
	task automatic t_pbar();
		int hw [4] = '{4, 5, 2, 1};
		for (int f = 0; f < 4; f++)
		begin
			run(3'h3, f[1:0], 1'b0, 1'b0);
			chk(w(H / 4, 0), 10'h3ac);
			chk(w(3 * H / 4, 0), 10'h040);
			chk(w(H - 1, 0), 10'h3ac);
			chk(w(H / 4 - 2 * hw[f], 0), 10'h040);
			chk(w(H / 4 + hw[f], 0), 10'h1f6);
		end
		// 4:2:2 chroma pulse is twice as wide as the luma pulse
		run(3'h3, 2'h2, 1'b1, 1'b0);
		chk(w(H / 4 + 4, 1), 10'h1f6);
		chk(w(H / 4 + 4, 0), 10'h040);
	endtask
	task automatic t_cpulse();
		run(3'h4, 2'h2, 1'b0, 1'b0);
		for (int s = 0; s < 8; s++)
			for (int k = 0; k < 3; k++)
			begin
				chk(w(s * H / 8 + H / 16, k), s[k] ? 10'h3ac : 10'h040);
				chk(w((V - 1) * H + s * H / 8 + H / 16, k), s[k] ? 10'h3ac : 10'h040);
			end
	endtask
	// ****************************************************************
	// Sequence and watchdog
	// ****************************************************************
	initial
	begin
		t_eq();
		t_eq422();
		t_stress(3'h1);
		t_stress(3'h2);
		t_cosite();
		t_pbar();
		t_cpulse();
		summarize();
	end
	initial
	begin
		#400000;
		miscompares++;
		summarize();
	end
endmodule

// [logic/scpg_fifo.sv]
// Output buffer of the check-pattern generator.
// The buffer module scpg_fifo is defined in logic/scpg_gen.sv beside the generator.
// This file holds no logic.

// [logic/scpg_gen.sv]
// Check-pattern generator: stress, pulse-and-bar, colour-pulse, co-siting fields.
// The output buffer FIFO module it feeds sits at the end of this file.
// Counts line/sample positions with its own raster counters and assumes that the
// output path pulls words through a ready handshake.
//
// Contract
// - Equalizer mode alternates 300h and 198h.
// - HD 4:2:2: luma 198h, chroma 300h.
// - Alternate frames start with 190h.
// - PLL mode alternates 200h and 110h.
// - Matrix: equalizer top, PLL bottom.
// - Co-siting: one-sample centre pulse, distinct amplitudes.
// - Pulse width chosen by video format.
// - Chroma pulses half bandwidth in 4:2:2.
// - Positive pulse on black, negative on bar.
// - Eight colour pulses, positive top, negative bottom.
`timescale 1ns/1ps
module scpg_gen #(
	parameter int H_ACTIVE = 1920, // Active samples per line
	parameter int V_ACTIVE = 1080 // Active lines per frame
)(
	input wire logic i_clk_sys, // 125 MHz clock
	input wire logic i_sys_rst, // Sync reset, active high
	input wire logic [2:0] i_pattern, // Pattern select
	input wire logic [1:0] i_format, // Format class
	input wire logic i_ycbcr422, // 4:2:2 YCbCr sampling
	output logic o_valid, // Sample triple available
	input wire logic i_ready, // Downstream accepts
	output logic [9:0] o_ch0, // Luma / green word
	output logic [9:0] o_ch1, // Cb / blue word
	output logic [9:0] o_ch2, // Cr / red word
	output logic o_sol, // First sample of line
	output logic o_sof // First sample of frame
);
	// Counters are 12 bits and eight colour segments need room for a pulse each
	if (H_ACTIVE < 64 || H_ACTIVE > 4095 || V_ACTIVE < 4 || V_ACTIVE > 4095)
	begin : g_raster_bad
		$error("Raster size out of range");
	end
	localparam logic [11:0] H_LAST = 12'(H_ACTIVE - 1);
	localparam logic [11:0] V_LAST = 12'(V_ACTIVE - 1);
	localparam logic [11:0] H_MID = 12'(H_ACTIVE / 2);
	localparam logic [11:0] V_MID = 12'(V_ACTIVE / 2);
	localparam logic [11:0] H_SEG = 12'(H_ACTIVE / 8);
	localparam logic [11:0] H_POS_CTR = 12'(H_SEG * 2); // Positive pulse centre
	localparam logic [11:0] H_NEG_CTR = 12'(H_SEG * 6); // Negative pulse centre on the bar
	// ****************************************************************
	// Helpers
	// ****************************************************************
	// Triangular pulse value: amp at centre, falling to zero at 2*haw away.
	// No shaping filter is applied; this keeps only the half-amplitude width.
	function automatic logic [9:0] tri_pulse(input logic [11:0] pos, input logic [11:0] ctr,
		input logic [3:0] haw, input logic [9:0] amp);
		logic [11:0] d;
		logic [15:0] span;
		logic [25:0] prod;
		d = (pos > ctr) ? pos - ctr : ctr - pos;
		span = {11'h000, haw, 1'b0};
		prod = '0;
		if ({4'h0, d} < span)
		begin
			prod = 26'(amp) * 26'(span - {4'h0, d});
			tri_pulse = 10'(prod / 26'(span));
		end
		else
			tri_pulse = 10'h000;
	endfunction
	// Pulse width by format class
	function automatic logic [3:0] fmt_haw(input logic [1:0] fmt);
		unique case (fmt)
			2'd0: fmt_haw = scpg_pkg::HAW_2T4;
			2'd1: fmt_haw = scpg_pkg::HAW_2T5;
			2'd2: fmt_haw = scpg_pkg::HAW_2T30;
			2'd3: fmt_haw = scpg_pkg::HAW_2T60;
		endcase
	endfunction
	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [11:0] h; // Sample position
		logic [11:0] v; // Line position
		logic odd_frame; // Frame parity for polarity word
	} scpg_st_t;
	scpg_st_t st;
	scpg_st_t next_st;
	logic fifo_ready; // Buffer has room
	logic [31:0] fifo_out; // Buffered word
	logic [9:0] c0, c1, c2; // Computed sample
	logic [3:0] haw_y, haw_c; // Luma/chroma widths
	logic lower; // Lower half of field
	logic even_word; // First word of a pair
	logic [9:0] pl_y, pl_c; // Pulse magnitudes
	logic [2:0] colour; // Colour index in pulse pattern
	logic [11:0] seg_ctr; // Centre of current colour segment
	logic line_start; // Current position opens a line
	logic frame_start; // Current position opens a frame
	// Pattern generation for the current position
	always_comb
	begin
		haw_y = fmt_haw(i_format);
		haw_c = i_ycbcr422 ? {haw_y[2:0], 1'b0} : haw_y;
		lower = st.v >= V_MID;
		even_word = !st.h[0];
		colour = 3'(st.h / H_SEG);
		seg_ctr = 12'(({9'h000, colour} * H_SEG) + (H_SEG >> 1));
		pl_y = 10'h000;
		pl_c = 10'h000;
		c0 = scpg_pkg::LVL_MIN;
		c1 = scpg_pkg::LVL_MIN;
		c2 = scpg_pkg::LVL_MIN;
		unique case (scpg_pkg::scpg_pat_t'(i_pattern))
			scpg_pkg::PAT_EQ, scpg_pkg::PAT_PLL, scpg_pkg::PAT_MATRIX:
			begin
				if (i_pattern == 3'(scpg_pkg::PAT_PLL) || (i_pattern == 3'(scpg_pkg::PAT_MATRIX) && lower))
				begin
					// Same alternate pair on every channel
					c0 = even_word ? scpg_pkg::PLL_WORD_HI : scpg_pkg::PLL_WORD_LO;
					c1 = c0;
					c2 = c0;
				end
				else if (i_ycbcr422)
				begin
					// Luma carries low word, chroma the high word
					c0 = scpg_pkg::EQ_WORD_LO;
					c1 = scpg_pkg::EQ_WORD_HI;
					c2 = scpg_pkg::EQ_WORD_HI;
					if (st.h == '0 && st.v == '0 && st.odd_frame)
						c0 = scpg_pkg::EQ_POL_WORD;
				end
				else
				begin
					c0 = even_word ? scpg_pkg::EQ_WORD_HI : scpg_pkg::EQ_WORD_LO;
					c1 = c0;
					c2 = c0;
					if (st.h == '0 && st.v == '0 && st.odd_frame)
					begin
						// First sample keeps 300h on c0 and c2 and puts the polarity word on c1
						c1 = scpg_pkg::EQ_POL_WORD;
					end
				end
			end
			scpg_pkg::PAT_PULSE_BAR:
			begin
				// Left half: positive pulse on black; right half: bar with negative pulse
				pl_y = tri_pulse(st.h, H_POS_CTR, haw_y, 10'(scpg_pkg::LVL_MAX - scpg_pkg::LVL_MIN));
				pl_c = tri_pulse(st.h, H_POS_CTR, haw_c, 10'(scpg_pkg::LVL_MAX - scpg_pkg::LVL_MIN));
				c0 = scpg_pkg::LVL_MIN + pl_y;
				c1 = scpg_pkg::LVL_MIN + pl_c;
				c2 = c1;
				if (st.h >= H_MID)
				begin
					pl_y = tri_pulse(st.h, H_NEG_CTR, haw_y, 10'(scpg_pkg::LVL_MAX - scpg_pkg::LVL_MIN));
					pl_c = tri_pulse(st.h, H_NEG_CTR, haw_c, 10'(scpg_pkg::LVL_MAX - scpg_pkg::LVL_MIN));
					c0 = scpg_pkg::LVL_MAX - pl_y;
					c1 = scpg_pkg::LVL_MAX - pl_c;
					c2 = c1;
				end
			end
			scpg_pkg::PAT_COLOR_PULSE:
			begin
				// Channels are G,B,R; in the top half a set colour bit means that channel pulses
				pl_y = tri_pulse(st.h, seg_ctr, haw_y, 10'(scpg_pkg::LVL_MAX - scpg_pkg::LVL_MIN));
				pl_c = tri_pulse(st.h, seg_ctr, haw_c, 10'(scpg_pkg::LVL_MAX - scpg_pkg::LVL_MIN));
				if (!lower)
				begin
					c0 = scpg_pkg::LVL_MIN + (colour[0] ? pl_y : 10'h000);
					c1 = scpg_pkg::LVL_MIN + (colour[1] ? pl_c : 10'h000);
					c2 = scpg_pkg::LVL_MIN + (colour[2] ? pl_c : 10'h000);
				end
				else
				begin
					// Subtract the complementary channels to keep the same line colour
					c0 = scpg_pkg::LVL_MAX - (colour[0] ? 10'h000 : pl_y);
					c1 = scpg_pkg::LVL_MAX - (colour[1] ? 10'h000 : pl_c);
					c2 = scpg_pkg::LVL_MAX - (colour[2] ? 10'h000 : pl_c);
				end
			end
			scpg_pkg::PAT_COSITE:
			begin
				if (st.h == H_MID && st.v == V_MID)
				begin
					c0 = scpg_pkg::COS_AMP_Y;
					c1 = scpg_pkg::COS_AMP_B;
					c2 = scpg_pkg::COS_AMP_R;
				end
			end
			default:
			begin
				// Unused codes give black
				c0 = scpg_pkg::LVL_MIN;
				c1 = scpg_pkg::LVL_MIN;
				c2 = scpg_pkg::LVL_MIN;
			end
		endcase
	end
	// Raster advance only when the buffer takes the word
	always_comb
	begin
		next_st = st;
		if (fifo_ready)
		begin
			if (st.h == H_LAST)
			begin
				next_st.h = '0;
				if (st.v == V_LAST)
				begin
					next_st.v = '0;
					next_st.odd_frame = !st.odd_frame;
				end
				else
					next_st.v = st.v + 12'h001;
			end
			else
				next_st.h = st.h + 12'h001;
		end
	end
	// Register state
	always_ff @(posedge i_clk_sys)
	begin
		if (i_sys_rst)
			st <= '0;
		else
			st <= next_st;
	end
	// Flags come from the same position as the word; a staged copy would lag one word
	assign line_start = st.h == '0;
	assign frame_start = st.h == '0 && st.v == '0;
	// Buffer between generator and output path; back-pressure stalls the raster
	scpg_fifo #(
		.WIDTH(32),
		.DEPTH(scpg_pkg::FIFO_DEPTH)
	) u_fifo (
		.i_clk_sys(i_clk_sys),
		.i_sys_rst(i_sys_rst),
		.i_in_valid(1'b1),
		.o_in_ready(fifo_ready),
		.i_in_data({frame_start, line_start, c2, c1, c0}),
		.o_out_valid(o_valid),
		.i_out_ready(i_ready),
		.o_out_data(fifo_out)
	);
	assign o_ch0 = fifo_out[9:0];
	assign o_ch1 = fifo_out[19:10];
	assign o_ch2 = fifo_out[29:20];
	assign o_sol = fifo_out[30];
	assign o_sof = fifo_out[31];
endmodule

// ****************************************************************
// Output buffer
// ****************************************************************
// Synchronous FIFO with valid/ready on both sides, one clock, sync reset.
// Storage has no reset: only the pointers decide which words are visible.
module scpg_fifo #(
	parameter int WIDTH = 32, // Word width
	parameter int DEPTH = 16 // Words held, a power of two
)(
	input wire logic i_clk_sys, // Clock
	input wire logic i_sys_rst, // Reset
	input wire logic i_in_valid, // Write request
	output logic o_in_ready, // Not full
	input wire logic [WIDTH-1:0] i_in_data, // Write data
	output logic o_out_valid, // Not empty
	input wire logic i_out_ready, // Read accept
	output logic [WIDTH-1:0] o_out_data // Head word
);
	localparam int AW = $clog2(DEPTH); // Pointer index width
	// Pointers wrap naturally, so only power-of-two depths are served
	if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
	begin : g_depth_bad
		$error("DEPTH must be a power of two >= 2");
	end
	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [AW:0] wp; // Write pointer with wrap bit
		logic [AW:0] rp; // Read pointer with wrap bit
	} scpg_fifo_st_t;
	scpg_fifo_st_t st;
	scpg_fifo_st_t next_st;
	logic [WIDTH-1:0] mem [DEPTH]; // Storage, no reset needed
	logic push; // Word accepted this cycle
	logic pop; // Word taken this cycle
	// Full when pointers differ only in the wrap bit
	assign o_in_ready = !((st.wp[AW] != st.rp[AW]) && (st.wp[AW-1:0] == st.rp[AW-1:0]));
	assign o_out_valid = st.wp != st.rp;
	assign push = i_in_valid && o_in_ready;
	assign pop = o_out_valid && i_out_ready;
	// Head read is direct from the array; o_out_data is not registered
	assign o_out_data = mem[st.rp[AW-1:0]];
	// Pointer update
	always_comb
	begin
		next_st = st;
		if (push)
			next_st.wp = st.wp + 1'b1;
		if (pop)
			next_st.rp = st.rp + 1'b1;
	end
	// Register state
	always_ff @(posedge i_clk_sys)
	begin
		if (i_sys_rst)
			st <= '0;
		else
			st <= next_st;
	end
	// Array write
	always_ff @(posedge i_clk_sys)
	begin
		if (push)
			mem[st.wp[AW-1:0]] <= i_in_data;
	end
endmodule

// [logic/scpg_pkg.sv]
// Package for the check-pattern generator: pattern codes, word values, formats.
// Assumes a 10-bit sample stream with one word per clock.
package scpg_pkg;
	// ****************************************************************
	// Stress words
	// ****************************************************************
	localparam logic [9:0] EQ_WORD_HI = 10'h300; // Equalizer high word
	localparam logic [9:0] EQ_WORD_LO = 10'h198; // Equalizer low word
	localparam logic [9:0] EQ_POL_WORD = 10'h190; // Polarity control word
	localparam logic [9:0] PLL_WORD_HI = 10'h200; // PLL high word
	localparam logic [9:0] PLL_WORD_LO = 10'h110; // PLL low word
	// ****************************************************************
	// Levels
	// ****************************************************************
	localparam logic [9:0] LVL_MIN = 10'h040; // Minimum legal value (black)
	localparam logic [9:0] LVL_MAX = 10'h3ac; // Maximum legal value (white)
	localparam logic [9:0] LVL_MID = 10'h200; // Chroma zero
	localparam logic [9:0] COS_AMP_Y = 10'h3ac; // Co-siting luma/G amplitude
	localparam logic [9:0] COS_AMP_B = 10'h300; // Co-siting channel 1 amplitude
	localparam logic [9:0] COS_AMP_R = 10'h280; // Co-siting channel 2 amplitude
	// ****************************************************************
	// Pulse half-amplitude widths in samples, per format class
	// ****************************************************************
	localparam logic [3:0] HAW_2T4 = 4'h4; // 525-line
	localparam logic [3:0] HAW_2T5 = 4'h5; // 625-line
	localparam logic [3:0] HAW_2T30 = 4'h2; // HD, slow 3G
	localparam logic [3:0] HAW_2T60 = 4'h1; // Fast 3G
	localparam int FIFO_DEPTH = 16; // Output buffer depth
	// Pattern selection
	typedef enum logic [2:0] {
		PAT_EQ,
		PAT_PLL,
		PAT_MATRIX,
		PAT_PULSE_BAR,
		PAT_COLOR_PULSE,
		PAT_COSITE
	} scpg_pat_t;
	// Video format class
	typedef enum logic [1:0] {
		FMT_SD525,
		FMT_SD625,
		FMT_HD,
		FMT_3G_FAST
	} scpg_fmt_t;
endpackage
